// >>> pin_mux_consts.svh
`ifndef PIN_MUX_CONSTS_SVH
`define PIN_MUX_CONSTS_SVH

// register byte offsets (printed offsets are even, not all multiples of 4)
`define SEL_REG_INDEX     12'h0C1A
`define PD_REG_INDEX      12'h0468
`define SEL_REG_ADDR      14'h3068
`define PD_REG_ADDR       14'h11A0
`define DATA_REG_ADDR     14'h0100
`define ADDR_W            14

// field layout
`define SEL_W             6
`define PD_W              3
`define NUM_PINS          3
`define SEL_RESET         6'h00
`define PD_RESET          3'h0
`define DATA_RESET        3'h0
`define OE_B_IDLE         3'h7
`define READ_ZERO         32'h0000_0000

// select encodings
`define SEL_INPUT         2'h0
`define SEL_RESERVED      2'h1
`define SEL_OUTPUT        2'h2
`define SEL_PANEL         2'h3

// data register: out bits [2:0], input bits [10:8] read only
`define DATA_IN_LSB       8

`endif

// >>> pin_mux_pkg.sv
package pin_mux_pkg;
    typedef enum logic [1:0] {
        func_input,
        func_reserved,
        func_output,
        func_panel
    } pin_func_t;

    typedef struct packed {
        logic [2:0] level;
        logic [2:0] oe_b;
        logic [2:0] pull_down;
    } pad_drive_t;

    typedef struct packed {
        logic [2:0] data;
        logic [2:0] oe_b;
    } panel_cmd_t;
endpackage

// >>> panel_port_g_pin_mux.sv
`timescale 1ns/1ps
`default_nettype none
`include "pin_mux_consts.svh"

// Summary of operation
// R01: Pin two follows select bits 5:4; 00 input, 10 output, 11 panel line.
// R02: Pin one follows select bits 3:2; 00 input, 10 output, 11 panel line.
// R03: Pin zero follows select bits 1:0; 00 input, 10 output, 11 panel line.
// R04: All select fields reset to 00 so every pin starts as an input.
// R05: Software must not write 01 to a select field; it is reserved.
// R06: Pull-down control bit 2 switches the pull-down on pin two.
// R07: Pull-down control bit 1 switches the pull-down on pin one.
// R08: Pull-down control bit 0 switches the pull-down on pin zero.
// R09: Output pins drive their data bit; input pins are sampled for reading.
module panel_port_g_pin_mux (
    input  wire logic                    ref_clk_in,
    input  wire logic                    rst_b_in,
    input  wire logic                    psel_in,
    input  wire logic                    penable_in,
    input  wire logic                    pwrite_in,
    input  wire logic [`ADDR_W-1:0]      paddr_in,
    input  wire logic [31:0]             pwdata_in,
    output logic      [31:0]             prdata_out,
    output logic                         pready_out,
    output logic                         pslverr_out,
    input  wire logic [2:0]              pin_level_in,
    output pin_mux_pkg::pad_drive_t      pad_out,
    input  wire pin_mux_pkg::panel_cmd_t panel_cmd_in,
    output logic      [2:0]              panel_pin_level_out
);
    import pin_mux_pkg::*;

    logic [`SEL_W-1:0]     sel;
    logic [`PD_W-1:0]      pull_dn;
    logic [`NUM_PINS-1:0]  out_data;
    logic [`NUM_PINS-1:0]  in_data;
    logic [31:0]           next_rdata;
    pad_drive_t            next_pad;
    logic                  wr_en;
    logic                  rd_en;
    logic                  hit;

    function automatic pin_func_t pin_func(input logic [`SEL_W-1:0] s,
                                           input int idx);
        pin_func = pin_func_t'(s[idx*2 +: 2]);
    endfunction

    function automatic logic addr_hit(input logic [`ADDR_W-1:0] a);
        addr_hit = (a == `SEL_REG_ADDR) || (a == `PD_REG_ADDR)
                || (a == `DATA_REG_ADDR);
    endfunction

    assign pready_out  = 1'b1;
    assign hit         = addr_hit(paddr_in);
    assign wr_en       = psel_in && penable_in && pwrite_in;
    assign rd_en       = psel_in && !penable_in && !pwrite_in;
    // unmapped access flagged during access phase
    assign pslverr_out = psel_in && penable_in && !hit;

    // select fields
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sel <= `SEL_RESET; // R04
        end else if (wr_en && paddr_in == `SEL_REG_ADDR) begin
            sel <= pwdata_in[`SEL_W-1:0]; // R01 R02 R03
        end
    end

    // pull-down controls
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pull_dn <= `PD_RESET;
        end else if (wr_en && paddr_in == `PD_REG_ADDR) begin
            pull_dn <= pwdata_in[`PD_W-1:0]; // R06 R07 R08
        end
    end

    // output data bits
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            out_data <= `DATA_RESET;
        end else if (wr_en && paddr_in == `DATA_REG_ADDR) begin
            out_data <= pwdata_in[`NUM_PINS-1:0];
        end
    end

    // input sampling, only for pins selected as input
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            in_data <= `DATA_RESET;
        end else begin
            for (int i = 0; i < `NUM_PINS; i++) begin
                if (pin_func(sel, i) == func_input) begin
                    in_data[i] <= pin_level_in[i]; // R09
                end
            end
        end
    end

    always_comb begin
        next_rdata = `READ_ZERO;
        unique case (paddr_in)
            `SEL_REG_ADDR:  next_rdata[`SEL_W-1:0] = sel;
            `PD_REG_ADDR:   next_rdata[`PD_W-1:0]  = pull_dn;
            `DATA_REG_ADDR: begin
                next_rdata[`NUM_PINS-1:0] = out_data;
                next_rdata[`DATA_IN_LSB +: `NUM_PINS] = in_data;
            end
            default:        next_rdata = `READ_ZERO;
        endcase
    end

    // read data captured in setup phase, valid in access phase
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            prdata_out <= `READ_ZERO;
        end else if (rd_en) begin
            prdata_out <= next_rdata;
        end
    end

    always_comb begin
        next_pad.pull_down = pull_dn; // R06 R07 R08
        for (int i = 0; i < `NUM_PINS; i++) begin
            unique case (pin_func(sel, i))
                func_output: begin
                    next_pad.level[i] = out_data[i]; // R09
                    next_pad.oe_b[i]  = 1'b0;
                end
                func_panel: begin
                    next_pad.level[i] = panel_cmd_in.data[i];
                    next_pad.oe_b[i]  = panel_cmd_in.oe_b[i];
                end
                // input and the reserved code leave the pin undriven
                default: begin
                    next_pad.level[i] = 1'b0;
                    next_pad.oe_b[i]  = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pad_out <= '{level: `DATA_RESET, oe_b: `OE_B_IDLE,
                         pull_down: `PD_RESET};
        end else begin
            pad_out <= next_pad; // R01 R02 R03
        end
    end

    // panel logic sees the pin level only when it owns the pin
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            panel_pin_level_out <= `DATA_RESET;
        end else begin
            for (int i = 0; i < `NUM_PINS; i++) begin
                panel_pin_level_out[i] <= (pin_func(sel, i) == func_panel)
                                          && pin_level_in[i];
            end
        end
    end

    a_sel_reset_input: assert property ( // R04
        @(posedge ref_clk_in) $rose(rst_b_in) |-> sel == `SEL_RESET
    ) else $error("select not cleared by reset");

    a_pin_two_out: assert property ( // R01
        @(posedge ref_clk_in) disable iff (!rst_b_in)
        sel[5:4] == `SEL_OUTPUT |=> !pad_out.oe_b[2]
            && pad_out.level[2] == $past(out_data[2])
    ) else $error("pin two output mismatch");

    a_pin_one_panel: assert property ( // R02
        @(posedge ref_clk_in) disable iff (!rst_b_in)
        sel[3:2] == `SEL_PANEL |=>
            pad_out.level[1] == $past(panel_cmd_in.data[1])
            && pad_out.oe_b[1] == $past(panel_cmd_in.oe_b[1])
    ) else $error("pin one panel mismatch");

    a_pin_zero_in: assert property ( // R03
        @(posedge ref_clk_in) disable iff (!rst_b_in)
        sel[1:0] == `SEL_INPUT |=> pad_out.oe_b[0]
    ) else $error("pin zero driven while input");

    a_pd_two: assert property ( // R06
        @(posedge ref_clk_in) disable iff (!rst_b_in)
        wr_en && paddr_in == `PD_REG_ADDR
            |=> ##1 pad_out.pull_down[2] == $past(pwdata_in[2], 2)
    ) else $error("pull-down two mismatch");

    // pull-down writes reach the pad two edges later
    a_pd_one: assert property ( // R07
        @(posedge ref_clk_in) disable iff (!rst_b_in)
        wr_en && paddr_in == `PD_REG_ADDR
            |=> ##1 pad_out.pull_down[1] == $past(pwdata_in[1], 2)
    ) else $error("pull-down one mismatch");

    a_pd_zero: assert property ( // R08
        @(posedge ref_clk_in) disable iff (!rst_b_in)
        wr_en && paddr_in == `PD_REG_ADDR
            |=> ##1 pad_out.pull_down[0] == $past(pwdata_in[0], 2)
    ) else $error("pull-down zero mismatch");

    a_input_sample: assert property ( // R09
        @(posedge ref_clk_in) disable iff (!rst_b_in)
        sel[1:0] == `SEL_INPUT |=> in_data[0] == $past(pin_level_in[0])
    ) else $error("input not sampled");

    a_input_two: assert property ( // R09
        @(posedge ref_clk_in) disable iff (!rst_b_in)
        sel[5:4] == `SEL_INPUT |=> in_data[2] == $past(pin_level_in[2])
    ) else $error("pin two input not sampled");

    // input bit keeps its last value once the pin is handed over
    a_input_hold: assert property ( // R09
        @(posedge ref_clk_in) disable iff (!rst_b_in)
        sel[1:0] != `SEL_INPUT |=> in_data[0] == $past(in_data[0])
    ) else $error("input bit changed while pin not input");

    // routing, one edge behind the select field
    a_pin_two_panel: assert property ( // R01
        @(posedge ref_clk_in) disable iff (!rst_b_in)
        sel[5:4] == `SEL_PANEL |=>
            pad_out.level[2] == $past(panel_cmd_in.data[2])
            && pad_out.oe_b[2] == $past(panel_cmd_in.oe_b[2])
    ) else $error("pin two panel mismatch");

    a_pin_two_in: assert property ( // R01
        @(posedge ref_clk_in) disable iff (!rst_b_in)
        sel[5:4] == `SEL_INPUT |=> pad_out.oe_b[2]
    ) else $error("pin two driven while input");

    a_pin_one_out: assert property ( // R02
        @(posedge ref_clk_in) disable iff (!rst_b_in)
        sel[3:2] == `SEL_OUTPUT |=> !pad_out.oe_b[1]
            && pad_out.level[1] == $past(out_data[1])
    ) else $error("pin one output mismatch");

    a_pin_one_in: assert property ( // R02
        @(posedge ref_clk_in) disable iff (!rst_b_in)
        sel[3:2] == `SEL_INPUT |=> pad_out.oe_b[1]
    ) else $error("pin one driven while input");

    a_pin_zero_out: assert property ( // R03
        @(posedge ref_clk_in) disable iff (!rst_b_in)
        sel[1:0] == `SEL_OUTPUT |=> !pad_out.oe_b[0]
            && pad_out.level[0] == $past(out_data[0])
    ) else $error("pin zero output mismatch");

    a_pin_zero_panel: assert property ( // R03
        @(posedge ref_clk_in) disable iff (!rst_b_in)
        sel[1:0] == `SEL_PANEL |=>
            pad_out.level[0] == $past(panel_cmd_in.data[0])
            && pad_out.oe_b[0] == $past(panel_cmd_in.oe_b[0])
    ) else $error("pin zero panel mismatch");

    // panel side sees a pin only while it owns it
    a_panel_two_level: assert property ( // R01
        @(posedge ref_clk_in) disable iff (!rst_b_in)
        sel[5:4] == `SEL_PANEL |=>
            panel_pin_level_out[2] == $past(pin_level_in[2])
    ) else $error("pin two level not passed to panel");

    a_panel_one_level: assert property ( // R02
        @(posedge ref_clk_in) disable iff (!rst_b_in)
        sel[3:2] == `SEL_PANEL |=>
            panel_pin_level_out[1] == $past(pin_level_in[1])
    ) else $error("pin one level not passed to panel");

    a_panel_zero_hidden: assert property ( // R03
        @(posedge ref_clk_in) disable iff (!rst_b_in)
        sel[1:0] != `SEL_PANEL |=> !panel_pin_level_out[0]
    ) else $error("pin zero level shown to panel");

    a_pad_reset_idle: assert property ( // R04
        @(posedge ref_clk_in) $rose(rst_b_in) |-> pad_out.oe_b == `OE_B_IDLE
            && pad_out.pull_down == `PD_RESET
            && panel_pin_level_out == `DATA_RESET
    ) else $error("pads not idle after reset");

    // register writes
    a_sel_write: assert property ( // R01 R02 R03
        @(posedge ref_clk_in) disable iff (!rst_b_in)
        wr_en && paddr_in == `SEL_REG_ADDR
            |=> sel == $past(pwdata_in[`SEL_W-1:0])
    ) else $error("select write lost");

    a_data_write: assert property ( // R09
        @(posedge ref_clk_in) disable iff (!rst_b_in)
        wr_en && paddr_in == `DATA_REG_ADDR
            |=> out_data == $past(pwdata_in[`NUM_PINS-1:0])
    ) else $error("output data write lost");

    // main scenarios
    c_output_mode: cover property (
        @(posedge ref_clk_in) sel[5:4] == `SEL_OUTPUT);
    c_panel_mode: cover property (
        @(posedge ref_clk_in) sel[3:2] == `SEL_PANEL);
    c_pd_on: cover property (
        @(posedge ref_clk_in) pull_dn == 3'h7);
    c_input_pulled: cover property (
        @(posedge ref_clk_in) sel[1:0] == `SEL_INPUT && pull_dn[0]);
    c_unmapped_access: cover property (
        @(posedge ref_clk_in) psel_in && penable_in && !hit);
endmodule
`default_nettype wire

// >>> pad_model.sv
`timescale 1ns/1ps
`default_nettype none
module pad_model (
    input  wire logic                   clk_in,
    input  wire pin_mux_pkg::pad_drive_t pad_in,
    input  wire logic [2:0]             ext_en_in,
    input  wire logic [2:0]             ext_val_in,
    output logic      [2:0]             level_out
);
    import pin_mux_pkg::*;
    logic [2:0] last = 3'h0;
    // undriven line without pull-down wanders every cycle
    always_ff @(posedge clk_in) begin
        last <= level_out;
    end
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            if (!pad_in.oe_b[i])
                level_out[i] = pad_in.level[i];
            else if (ext_en_in[i])
                level_out[i] = ext_val_in[i];
            else if (pad_in.pull_down[i])
                level_out[i] = 1'b0;
            else
                level_out[i] = ~last[i];
        end
    end
endmodule
`default_nettype wire

// >>> panel_port_g_pin_mux_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "pin_mux_consts.svh"
module panel_port_g_pin_mux_tb;
    import pin_mux_pkg::*;
    logic        clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
    logic [13:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic        pready, pslverr, err;
    logic [2:0]  lvl, plvl, en = '0, ev = '0, pd, dat;
    logic [5:0]  sel;
    pad_drive_t  pad;
    panel_cmd_t  pcmd = '0;
    int          miscompares = 0, tests_run = 0;
    always #10 clk = ~clk;
    panel_port_g_pin_mux panel_port_g_pin_mux_inst (.ref_clk_in(clk),
        .rst_b_in(rst_b), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .pin_level_in(lvl), .pad_out(pad), .panel_cmd_in(pcmd),
        .panel_pin_level_out(plvl));
    pad_model pad_model_inst (.clk_in(clk), .pad_in(pad), .ext_en_in(en),
        .ext_val_in(ev), .level_out(lvl));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [13:0] a,
                       input logic [31:0] d);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk) penable <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge clk);
    endtask
    function automatic logic drives(input logic [1:0] s, input logic ob);
        drives = s == `SEL_OUTPUT || (s == `SEL_PANEL && !ob);
    endfunction
    task automatic check_pins;
        logic drv, dv, lv;
        logic [1:0] s;
        @(negedge clk);
        for (int i = 0; i < 3; i++) begin
            s = sel[2*i+:2];
            drv = drives(s, pcmd.oe_b[i]);
            dv = s == 2'h2 ? dat[i] : pcmd.data[i];
            lv = drv ? dv : en[i] & ev[i];
            chk(pad.oe_b[i], !drv);
            chk(pad.pull_down[i], pd[i]);
            if (drv) chk(pad.level[i], dv);
            if (drv | en[i] | pd[i]) begin
                if (s == 2'h0) chk(rd[8+i], lv);
                chk(plvl[i], s == 2'h3 ? lv : 1'b0);
            end
        end
        @(posedge clk);
    endtask
    task report_and_stop;
        $display("compares=%0d mismatches=%0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        report_and_stop;
    end
    initial begin
        void'($urandom(32'ha787));
        repeat (8) @(posedge clk);
        rst_b <= 1;
        @(posedge clk);
        apb(0, `SEL_REG_ADDR, 32'h0);
        chk(rd, 32'h0);
        apb(1, 14'h0004, 32'hffff_ffff);
        chk(err, 32'h1);
        for (int k = 0; k < 24; k++) begin
            sel = k == 0 ? 6'h2a : k == 1 ? 6'h3f : 6'($urandom);
            // reserved code never written by software
            for (int i = 0; i < 3; i++)
                if (sel[2*i+:2] == 2'h1) sel[2*i+1] = 1'b1;
            pd = 3'($urandom);
            dat = 3'($urandom);
            en <= 3'($urandom);
            ev <= 3'($urandom);
            pcmd <= 6'($urandom);
            apb(1, `SEL_REG_ADDR, {26'h0, sel});
            apb(1, `PD_REG_ADDR, {29'h0, pd});
            apb(1, `DATA_REG_ADDR, {29'h0, dat});
            repeat (2) @(posedge clk);
            apb(0, `SEL_REG_ADDR, 32'h0);
            chk(rd, {26'h0, sel});
            apb(0, `DATA_REG_ADDR, 32'h0);
            chk(rd[2:0], dat);
            check_pins;
        end
        apb(0, 14'h0004, 32'h0);
        chk(rd, 32'h0);
        rst_b <= 0;
        repeat (2) @(posedge clk);
        rst_b <= 1;
        @(posedge clk);
        apb(0, `SEL_REG_ADDR, 32'h0);
        chk(rd, 32'h0);
        chk(pad.oe_b, 32'h7);
        report_and_stop;
    end
endmodule
`default_nettype wire
